// file: hw/psp_pkg.sv
package psp_pkg;
  // sfr bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_W = 3;
  localparam int unsigned SLOTS  = 4;

  // page register location, outside the paged set
  localparam logic [7:0] PAGE_REG_ADDR = 8'hA3;

  // paged address windows
  localparam logic [7:0] WIN_A_LO = 8'h9A;
  localparam logic [7:0] WIN_A_HI = 8'h9F;
  localparam logic [7:0] WIN_B_LO = 8'hA4;
  localparam logic [7:0] WIN_B_HI = 8'hA7;
  localparam logic [7:0] WIN_C_LO = 8'hFA;
  localparam logic [7:0] WIN_C_HI = 8'hFF;
  localparam logic [7:0] HOLE_LO  = 8'hA5;
  localparam logic [2:0] HOLE_PAGE = 3'h3;

  // field positions of the page register
  localparam int unsigned PAGE_LSB = 0;
  localparam int unsigned RSVD_BIT = 3;
  localparam int unsigned SLOT_LSB = 4;
  localparam int unsigned OP_LSB   = 6;

  // operation codes (upper bit zero means direct load)
  localparam logic [1:0] OP_SAVE    = 2'h2;
  localparam logic [1:0] OP_RESTORE = 2'h3;

  // reset values
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic [2:0] SLOT_RST = 3'h0;
endpackage : psp_pkg

// file: hw/psp_decode.sv
`timescale 1ns/1ps
// combinational decode of one sfr address into a paged register select
module psp_decode (
  input  wire logic [7:0] addr_i,
  input  wire logic [2:0] page_i,
  input  wire logic       map_sel_i,
  output logic            hit_o,
  output logic [5:0]      index_o
);
  logic [3:0] off;
  logic       in_win;

  always_comb begin
    off    = 4'h0;
    in_win = 1'b0;
    if (addr_i >= psp_pkg::WIN_A_LO && addr_i <= psp_pkg::WIN_A_HI) begin
      in_win = 1'b1;
      off    = 4'(addr_i - psp_pkg::WIN_A_LO);
    end else if (addr_i >= psp_pkg::WIN_B_LO && addr_i <= psp_pkg::WIN_B_HI) begin
      in_win = 1'b1;
      off    = 4'(addr_i - psp_pkg::WIN_B_LO + 8'h06);
    end else if (addr_i >= psp_pkg::WIN_C_LO && addr_i <= psp_pkg::WIN_C_HI) begin
      in_win = 1'b1;
      off    = 4'(addr_i - psp_pkg::WIN_C_LO + 8'h0A);
    end
    // page three leaves the upper part of the second window empty
    if (page_i == psp_pkg::HOLE_PAGE && addr_i >= psp_pkg::HOLE_LO &&
        addr_i <= psp_pkg::WIN_B_HI) begin
      in_win = 1'b0;
    end
    // page bit 2 has no registers behind it
    hit_o   = in_win && !map_sel_i && !page_i[2];
    index_o = {page_i[1:0], off};
  end
endmodule : psp_decode

// file: hw/psp_page_select.sv
`timescale 1ns/1ps
// Functional notes
// - three-bit active page in bits 2:0; write sets it, read returns it
// - operation code 0x loads page directly, slot selector ignored
// - operation code 10 saves old page to selected slot, loads new page
// - operation code 11 restores page from selected slot, written page ignored
// - slot selector bits 5:4 pick slot zero through three
// - reserved bit 3 reads zero
// - addresses 9A-9F, A4-A7, FA-FF decode per page; page three lacks A5-A7
// - page register sits at A3, reachable on any page
// - paged registers answer only with map select zero, four pages
// - operation code and slot selector read back as zero
module psp_page_select (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic       sfr_map_select_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            sfr_rd_hit_o,
  output logic [2:0]      active_page_o,
  output logic            paged_sel_o,
  output logic [5:0]      paged_index_o,
  output logic            paged_wr_o,
  output logic            paged_rd_o
);
  typedef struct packed {
    logic [2:0]       page;
    logic [3:0][2:0]  slot;
    logic [7:0]       rdata;
    logic             rd_hit;
    logic             psel;
    logic [5:0]       pidx;
    logic             pwr;
    logic             prd;
  } psp_state_s;

  psp_state_s st_q;
  psp_state_s st_d;

  logic       dec_hit;
  logic [5:0] dec_idx;
  logic       page_hit;
  logic [1:0] op_code;
  logic [1:0] slot_sel;
  logic [2:0] wr_page;

  // decode uses the page in effect before any write this cycle
  psp_decode u_dec (
    .addr_i    (sfr_addr_i),
    .page_i    (st_q.page),
    .map_sel_i (sfr_map_select_i),
    .hit_o     (dec_hit),
    .index_o   (dec_idx)
  );

  // the page register stays reachable whatever page is active
  assign page_hit = (sfr_addr_i == psp_pkg::PAGE_REG_ADDR) && !sfr_map_select_i;
  assign op_code  = sfr_wdata_i[psp_pkg::OP_LSB +: 2];
  assign slot_sel = sfr_wdata_i[psp_pkg::SLOT_LSB +: 2];
  assign wr_page  = sfr_wdata_i[psp_pkg::PAGE_LSB +: 3];

  always_comb begin
    st_d        = st_q;
    st_d.rd_hit = 1'b0;
    st_d.rdata  = 8'h00;
    if (sfr_wr_i && page_hit) begin
      if (!op_code[1]) begin
        st_d.page = wr_page;
      end else if (op_code == psp_pkg::OP_SAVE) begin
        st_d.slot[slot_sel] = st_q.page;
        st_d.page           = wr_page;
      end else begin
        st_d.page = st_q.slot[slot_sel];
      end
    end
    if (sfr_rd_i && page_hit) begin
      st_d.rd_hit = 1'b1;
      // op, slot selector and reserved bit all read zero
      st_d.rdata  = {5'h00, st_q.page};
    end
    // paged strobes go out registered; behind-registers answer the reads themselves
    st_d.psel = dec_hit && (sfr_wr_i || sfr_rd_i);
    st_d.pidx = dec_idx;
    st_d.pwr  = dec_hit && sfr_wr_i;
    st_d.prd  = dec_hit && sfr_rd_i;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q.page   <= psp_pkg::PAGE_RST;
      st_q.slot   <= {4{psp_pkg::SLOT_RST}};
      st_q.rdata  <= 8'h00;
      st_q.rd_hit <= 1'b0;
      st_q.psel   <= 1'b0;
      st_q.pidx   <= 6'h00;
      st_q.pwr    <= 1'b0;
      st_q.prd    <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata_o   = st_q.rdata;
  assign sfr_rd_hit_o  = st_q.rd_hit;
  assign active_page_o = st_q.page;
  assign paged_sel_o   = st_q.psel;
  assign paged_index_o = st_q.pidx;
  assign paged_wr_o    = st_q.pwr;
  assign paged_rd_o    = st_q.prd;

  a_direct_load : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && page_hit && !sfr_wdata_i[7]) |=> (active_page_o == $past(sfr_wdata_i[2:0])))
    else $error("direct page load failed");

  a_save_slot : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && page_hit && sfr_wdata_i[7:6] == 2'h2)
    |=> (st_q.slot[$past(sfr_wdata_i[5:4])] == $past(active_page_o)) &&
        (active_page_o == $past(sfr_wdata_i[2:0])))
    else $error("save operation wrong");

  a_restore_slot : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && page_hit && sfr_wdata_i[7:6] == 2'h3)
    |=> (active_page_o == $past(st_q.slot[sfr_wdata_i[5:4]])))
    else $error("restore operation wrong");

  a_read_zeros : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    sfr_rd_hit_o |-> (sfr_rdata_o[7:3] == 5'h00))
    else $error("write-only or reserved bits read nonzero");

  a_read_page : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_rd_i && page_hit) |=> sfr_rd_hit_o && (sfr_rdata_o[2:0] == $past(active_page_o)))
    else $error("page readback wrong");

  a_hole_page3 : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (active_page_o == 3'h3 && sfr_rd_i && sfr_addr_i >= 8'hA5 && sfr_addr_i <= 8'hA7)
    |=> !paged_sel_o)
    else $error("page three hole decoded");

  a_map_gate : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    sfr_map_select_i |=> !paged_sel_o && !sfr_rd_hit_o)
    else $error("response with map select set");

  a_page_held : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !(sfr_wr_i && page_hit) |=> $stable(active_page_o))
    else $error("page changed without a write");

  a_window_hit : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_rd_i && !sfr_map_select_i && active_page_o == 3'h1 && sfr_addr_i == 8'hFF)
    |=> paged_sel_o && paged_index_o == 6'h1F)
    else $error("paged decode wrong");

  // paged decode and strobes, one cycle after the access is taken
  a_index_low : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_rd_i && !sfr_map_select_i && active_page_o == 3'h2 && sfr_addr_i == 8'h9A)
    |=> paged_sel_o && paged_index_o == 6'h20)
    else $error("first window decode wrong");

  a_index_mid : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_rd_i && !sfr_map_select_i && active_page_o == 3'h0 && sfr_addr_i == 8'hA4)
    |=> paged_sel_o && paged_index_o == 6'h06)
    else $error("second window decode wrong");

  a_wr_strobe : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && !sfr_rd_i && !sfr_map_select_i && active_page_o == 3'h0 && sfr_addr_i == 8'hFA)
    |=> paged_wr_o && !paged_rd_o && paged_index_o == 6'h0A)
    else $error("paged write strobe wrong");

  a_hole_write : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (active_page_o == 3'h3 && sfr_wr_i && sfr_addr_i >= 8'hA5 && sfr_addr_i <= 8'hA7)
    |=> !paged_wr_o)
    else $error("page three hole written");

  a_unmapped_addr : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_addr_i < 8'h9A) |=> !paged_sel_o)
    else $error("address below the windows decoded");

  a_high_pages : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    active_page_o[2] |=> !paged_sel_o)
    else $error("page four or above decoded");

  a_paged_kind : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    paged_sel_o == (paged_wr_o || paged_rd_o))
    else $error("paged select without a kind");

  // page register writes and the storage slots
  a_rsvd_write : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && page_hit && sfr_wdata_i[3] && !sfr_wdata_i[7])
    |=> active_page_o == $past(sfr_wdata_i[2:0]))
    else $error("reserved bit disturbed the page");

  a_op01_load : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && page_hit && sfr_wdata_i[7:6] == 2'h1)
    |=> (active_page_o == $past(sfr_wdata_i[2:0])) && $stable(st_q.slot))
    else $error("direct load with low op bit set wrong");

  a_slot_select : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && page_hit && sfr_wdata_i[7:6] == 2'h2)
    |=> (st_q.slot[$past(slot_sel) ^ 2'h1] == $past(st_q.slot[slot_sel ^ 2'h1])) &&
        (st_q.slot[$past(slot_sel) ^ 2'h2] == $past(st_q.slot[slot_sel ^ 2'h2])) &&
        (st_q.slot[$past(slot_sel) ^ 2'h3] == $past(st_q.slot[slot_sel ^ 2'h3])))
    else $error("save touched another slot");

  a_slot_keep : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !(sfr_wr_i && page_hit && sfr_wdata_i[7:6] == 2'h2) |=> $stable(st_q.slot))
    else $error("slot changed without a save");

  a_page_reach : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_wr_i && sfr_addr_i == 8'hA3 && !sfr_map_select_i && active_page_o[2] && !sfr_wdata_i[7])
    |=> active_page_o == $past(sfr_wdata_i[2:0]))
    else $error("page register unreachable from a high page");

  a_map_write : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    (sfr_map_select_i && sfr_wr_i) |=> $stable(active_page_o) && $stable(st_q.slot))
    else $error("write with map select set took effect");

  a_rd_idle : assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !(sfr_rd_i && page_hit) |=> !sfr_rd_hit_o && (sfr_rdata_o == 8'h00))
    else $error("read answer without a page register read");

  // judged one edge later: the very first edge may come before any reset event
  a_reset_clear : assert property (@(posedge clock_i)
    !arst_n_i |=> (active_page_o == 3'h0) && (st_q.slot == '0))
    else $error("reset left page or slots set");
endmodule : psp_page_select

// file: verif/tb_psp_page_select.sv
`timescale 1ns/1ps
module tb_psp_page_select;
  logic       clock_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic       sfr_rd_i = 1'b0;
  logic       sfr_map_select_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic       sfr_rd_hit_o;
  logic [2:0] active_page_o;
  logic       paged_sel_o;
  logic [5:0] paged_index_o;
  logic       paged_wr_o;
  logic       paged_rd_o;
  logic [2:0] page_m = 3'h0;
  logic [2:0] slot_m [4] = '{default: 3'h0};
  logic [7:0] a;
  int         errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         seed = 63616;
  int         r;

  psp_page_select dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_map_select_i(sfr_map_select_i), .sfr_rdata_o(sfr_rdata_o),
    .sfr_rd_hit_o(sfr_rd_hit_o), .active_page_o(active_page_o),
    .paged_sel_o(paged_sel_o), .paged_index_o(paged_index_o),
    .paged_wr_o(paged_wr_o), .paged_rd_o(paged_rd_o)
  );

  always #25 clock_i = ~clock_i;

  task automatic final_report();
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // generous ceiling: the sequence needs well under 500 cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      errors++;
      final_report();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask : cmp

  // returns {hit, page[1:0], offset}
  function automatic logic [6:0] exp_paged(input logic [7:0] ad, input logic [2:0] p,
                                           input logic m);
    logic [3:0] s;
    logic       h;
    h = 1'b1;
    s = 4'h0;
    if (ad >= 8'h9A && ad <= 8'h9F) s = 4'(ad - 8'h9A);
    else if (ad >= 8'hA4 && ad <= 8'hA7) s = 4'(ad - 8'h9E);
    else if (ad >= 8'hFA) s = 4'(ad - 8'hF0);
    else h = 1'b0;
    if (m || p[2] || (p == 3'h3 && ad >= 8'hA5 && ad <= 8'hA7)) h = 1'b0;
    return {h, p[1:0], s};
  endfunction : exp_paged

  // strobes are left up so back-to-back accesses never reassign them in one step
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic m);
    logic [6:0] e;
    logic       pr;
    e = exp_paged(ad, page_m, m);
    pr = !m && ad == 8'hA3;
    sfr_wr_i = w;
    sfr_rd_i = ~w;
    sfr_addr_i = ad;
    sfr_wdata_i = d;
    sfr_map_select_i = m;
    @(posedge clock_i);
    #1;
    if (w && pr) begin
      if (d[7] && d[6]) page_m = slot_m[d[5:4]];
      else begin
        if (d[7]) slot_m[d[5:4]] = page_m;
        page_m = d[2:0];
      end
    end
    cmp(8'(active_page_o), 8'(page_m), "page");
    cmp(8'(sfr_rd_hit_o), 8'(!w && pr), "read hit");
    cmp(sfr_rdata_o, (!w && pr) ? {5'h00, page_m} : 8'h00, "read data");
    cmp(8'({paged_sel_o, paged_wr_o, paged_rd_o}), 8'({e[6], e[6] & w, e[6] & ~w}),
        "paged strobes");
    if (e[6]) cmp(8'(paged_index_o), 8'(e[5:0]), "paged index");
  endtask : acc

  initial begin
    repeat (3) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    cmp(8'(active_page_o), 8'h00, "reset page");
    for (int s = 0; s < 4; s++) acc(1'b1, 8'hA3, 8'(8'hC7 | (s << 4)), 1'b0);
    acc(1'b1, 8'hA3, 8'h75, 1'b0);
    for (int s = 0; s < 4; s++) acc(1'b1, 8'hA3, 8'(8'h80 | (s << 4) | s + 1), 1'b0);
    for (int s = 0; s < 4; s++) acc(1'b1, 8'hA3, 8'(8'hC0 | (s << 4)), 1'b0);
    acc(1'b1, 8'hA3, 8'h03, 1'b0);
    acc(1'b0, 8'hA5, 8'h00, 1'b0);
    acc(1'b0, 8'hA3, 8'h00, 1'b1);
    acc(1'b1, 8'hA6, 8'h00, 1'b0);
    acc(1'b1, 8'hA3, 8'h81, 1'b1);
    acc(1'b1, 8'hA3, 8'h0E, 1'b0);
    acc(1'b0, 8'hA3, 8'h00, 1'b0);
    acc(1'b1, 8'hA3, 8'h01, 1'b0);
    acc(1'b0, 8'hFF, 8'h00, 1'b0);
    acc(1'b1, 8'hA3, 8'h02, 1'b0);
    acc(1'b0, 8'h9A, 8'h00, 1'b0);
    acc(1'b1, 8'hA3, 8'h00, 1'b0);
    acc(1'b0, 8'hA4, 8'h00, 1'b0);
    acc(1'b1, 8'hFA, 8'h5A, 1'b0);
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      case (r[2:1])
        2'h0: a = 8'hA3;
        2'h1: a = 8'(8'h98 + r[7:4]);
        2'h2: a = {4'hF, r[7:4]};
        default: a = r[15:8];
      endcase
      acc(r[3], a, r[31:24] & 8'hF7, r[20:16] == 5'h00);
    end
    // fill the slots, then a reset in mid-run must clear them again
    for (int s = 0; s < 4; s++) acc(1'b1, 8'hA3, 8'(8'h85 | (s << 4)), 1'b0);
    arst_n_i = 1'b0;
    page_m = 3'h0;
    slot_m = '{default: 3'h0};
    @(posedge clock_i);
    #1;
    cmp(8'(active_page_o), 8'h00, "page in reset");
    cmp({4'h0, sfr_rd_hit_o, paged_sel_o, paged_wr_o, paged_rd_o}, 8'h00, "reset");
    arst_n_i = 1'b1;
    for (int s = 0; s < 4; s++) acc(1'b1, 8'hA3, 8'(8'hC7 | (s << 4)), 1'b0);
    final_report();
  end
endmodule : tb_psp_page_select
